// >>> core/phy_misc_pkg.sv
package phy_misc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS   = 40000;
  localparam int SOFT_RESET_NS   = 320;
  localparam int RESTART_NS      = 800;
  localparam int PHASE_SETTLE_NS = 200;
  localparam int SOFT_RESET_CYC  = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESTART_CYC     = (RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PHASE_SETTLE_CYC = (PHASE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W           = 16;

  // ==========================================================
  // Phase shift field
  localparam int PHASE_STEP_NS = 4;
  localparam int PHASE_W       = 4;
  localparam int PHASE_LIMIT   = 10;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam int IDX_W = 9;
  localparam logic [IDX_W-1:0] IDX_RESET_CTRL = 9'h01f;
  localparam logic [IDX_W-1:0] IDX_PHASE      = 9'h042;
  localparam logic [IDX_W-1:0] IDX_BACKOFF    = 9'h0ae;
  localparam logic [IDX_W-1:0] IDX_REGULATOR  = 9'h0d0;
  localparam logic [IDX_W-1:0] IDX_LENGTH     = 9'h155;

  // ==========================================================
  // Field positions
  localparam int B_SOFT_RESET = 15;
  localparam int B_RESTART    = 14;
  localparam int B_SHIFT_EN   = 4;
  localparam int B_BACKOFF_LO = 6;
  localparam int B_REG_PD     = 15;
  localparam int B_LEN_START  = 15;
  localparam int B_LEN_DONE   = 12;
  localparam int B_LEN_RES_LO = 4;

  // ==========================================================
  // Reset and fixed read values
  localparam logic [15:0] BACKOFF_FIXED = 16'h8020;
  localparam logic [2:0]  LEN_AVG_RESET = 3'h1;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_STEP   = 2'b01,
    PH_SETTLE = 2'b11
  } phase_state_t;

endpackage : phy_misc_pkg

// >>> core/phase_stepper.sv
`timescale 1ns/1ps

module phase_stepper #(
  parameter int PHASE_W       = phy_misc_pkg::PHASE_W,
  parameter int SETTLE_CYCLES = phy_misc_pkg::PHASE_SETTLE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               start,
  input  wire logic [PHASE_W-1:0] target,
  output logic                    busy,
  output logic [PHASE_W-1:0]      phase
);

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= 2 ** phy_misc_pkg::CNT_W) begin : g_chk
    $error("phase_stepper: SETTLE_CYCLES out of range");
  end

  phy_misc_pkg::phase_state_t       state_reg;
  logic [PHASE_W-1:0]               target_reg;
  logic [phy_misc_pkg::CNT_W-1:0]   settle_reg;

  assign busy = (state_reg != phy_misc_pkg::PH_IDLE);

  // ==========================================================
  // Walk one step at a time so the clock never glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= phy_misc_pkg::PH_IDLE;
      target_reg <= '0;
      settle_reg <= '0;
      phase      <= '0;
    end else begin
      case (state_reg)
        phy_misc_pkg::PH_IDLE: begin
          if (start) begin
            target_reg <= target;
            state_reg  <= phy_misc_pkg::PH_STEP;
          end
        end
        phy_misc_pkg::PH_STEP: begin
          if (phase == target_reg) begin
            state_reg <= phy_misc_pkg::PH_IDLE;
          end else begin
            phase      <= (phase < target_reg) ? phase + 1'b1 : phase - 1'b1;
            settle_reg <= phy_misc_pkg::CNT_W'(SETTLE_CYCLES - 1);
            state_reg  <= phy_misc_pkg::PH_SETTLE;
          end
        end
        phy_misc_pkg::PH_SETTLE: begin
          if (settle_reg == '0) begin
            state_reg <= phy_misc_pkg::PH_STEP;
          end else begin
            settle_reg <= settle_reg - 1'b1;
          end
        end
        default: state_reg <= phy_misc_pkg::PH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  property p_single_step;
    @(posedge clk) disable iff (!rst_n)
    (phase != $past(phase)) |-> (phase == $past(phase) + 1'b1 || phase == $past(phase) - 1'b1);
  endproperty
  a_single_step: assert property (p_single_step) else $error("phase moved more than one step");

  property p_done_on_target;
    @(posedge clk) disable iff (!rst_n)
    $fell(busy) |-> (phase == target_reg);
  endproperty
  a_done_on_target: assert property (p_done_on_target) else $error("shift ended off target");

endmodule : phase_stepper

// >>> core/phy_misc_control_regs.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps

// Behaviour
// - Reset-control bit 15 write resets whole block like hardware reset, then clears.
// - Reset-control bit 14 write restarts circuitry, keeps registers, clears when done.
// - Reserved read-only bits ignore writes and read zero, except back-off bits 15 and 5, which read one.
// - Transmit clock phase is fixed relative to the reference clock, programmable.
// - Phase field counts 4 ns steps, legal range 0 to 10.
// - Phase values above 10 are stored and applied modulo 10.
// - Phase field reads last written value; a shift moves clock by the difference.
// - Phase-shift enable bit 4 applies the field, then clears; zero changes nothing.
// - Back-off bits 8:6 select transmit power level by cable length.
// - Regulator bit 15 write powers regulator down, then the bit clears.
// - Length-detect bits 2:0 hold averaging factor, reset value 001.
module phy_misc_control_regs #(
  parameter int SOFT_RESET_CYCLES = phy_misc_pkg::SOFT_RESET_CYC,
  parameter int RESTART_CYCLES    = phy_misc_pkg::RESTART_CYC,
  parameter int SETTLE_CYCLES     = phy_misc_pkg::PHASE_SETTLE_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire phy_misc_pkg::wb_req_t wb_req,
  output phy_misc_pkg::wb_rsp_t      wb_rsp,
  output logic                       restart_active,
  output logic [3:0]                 tx_clk_phase,
  output logic [2:0]                 back_off_level,
  output logic                       regulator_power_down,
  output logic [3:0]                 regulator_ctrl,
  output logic                       length_detect_start,
  output logic [2:0]                 length_detect_avg,
  input  wire logic                  length_detect_done,
  input  wire logic [7:0]            length_detect_result
);

  localparam int CW = phy_misc_pkg::CNT_W;

  if (SOFT_RESET_CYCLES < 1 || RESTART_CYCLES < 1 ||
      SOFT_RESET_CYCLES >= 2 ** CW || RESTART_CYCLES >= 2 ** CW) begin : g_chk
    $error("phy_misc_control_regs: cycle counts out of range");
  end

  // ==========================================================
  // Reset: hardware reset synchroniser plus software reset
  logic [1:0]    rst_sync_reg;
  logic          hw_rst_n;
  logic          core_rst_n;
  logic          soft_active_reg;
  logic [CW-1:0] soft_cnt_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign hw_rst_n   = rst_sync_reg[1];
  assign core_rst_n = hw_rst_n & ~soft_active_reg;

  // ==========================================================
  // Bus decode
  logic                          acc;
  logic                          ack_reg;
  logic                          wr;
  logic                          wr_lo;
  logic                          wr_hi;
  logic [phy_misc_pkg::IDX_W-1:0] idx;
  logic                          in_range;
  logic [15:0]                   wdat;
  logic [15:0]                   wmask;
  logic                          hit_rst;
  logic                          hit_phase;
  logic                          hit_bo;
  logic                          hit_vr;
  logic                          hit_len;

  assign acc       = wb_req.cyc & wb_req.stb;
  assign idx       = wb_req.adr[phy_misc_pkg::IDX_W+1:2];
  assign in_range  = (wb_req.adr[15:phy_misc_pkg::IDX_W+2] == '0);
  assign wr        = acc & wb_req.we & ack_reg & in_range;
  assign wr_lo     = wr & wb_req.sel[0];
  assign wr_hi     = wr & wb_req.sel[1];
  assign wdat      = wb_req.dat[15:0];
  assign wmask     = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  assign hit_rst   = (idx == phy_misc_pkg::IDX_RESET_CTRL);
  assign hit_phase = (idx == phy_misc_pkg::IDX_PHASE);
  assign hit_bo    = (idx == phy_misc_pkg::IDX_BACKOFF);
  assign hit_vr    = (idx == phy_misc_pkg::IDX_REGULATOR);
  assign hit_len   = (idx == phy_misc_pkg::IDX_LENGTH);

  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [15:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  function automatic logic [3:0] fold_phase(input logic [3:0] v);
    fold_phase = (v > 4'(phy_misc_pkg::PHASE_LIMIT)) ? v - 4'(phy_misc_pkg::PHASE_LIMIT) : v;
  endfunction : fold_phase

  logic soft_req;
  logic restart_req;
  assign soft_req    = wr_hi & hit_rst & wdat[phy_misc_pkg::B_SOFT_RESET];
  assign restart_req = wr_hi & hit_rst & wdat[phy_misc_pkg::B_RESTART];

  // ==========================================================
  // Software reset counter, cleared only by hardware reset
  always_ff @(posedge clk or negedge hw_rst_n) begin
    if (!hw_rst_n) begin
      soft_active_reg <= 1'b0;
      soft_cnt_reg    <= '0;
    end else if (soft_req) begin
      soft_active_reg <= 1'b1;
      soft_cnt_reg    <= CW'(SOFT_RESET_CYCLES - 1);
    end else if (soft_active_reg) begin
      if (soft_cnt_reg == '0) begin
        soft_active_reg <= 1'b0;
      end else begin
        soft_cnt_reg <= soft_cnt_reg - 1'b1;
      end
    end
  end

  // ==========================================================
  // Restart: registers keep their values
  logic [CW-1:0] restart_cnt_reg;

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      restart_active  <= 1'b0;
      restart_cnt_reg <= '0;
    end else if (restart_req && !restart_active) begin
      restart_active  <= 1'b1;
      restart_cnt_reg <= CW'(RESTART_CYCLES - 1);
    end else if (restart_active) begin
      if (restart_cnt_reg == '0) begin
        restart_active <= 1'b0;
      end else begin
        restart_cnt_reg <= restart_cnt_reg - 1'b1;
      end
    end
  end

  // ==========================================================
  // Transmit clock phase
  logic [3:0] phase_field_reg;
  logic       phase_busy;
  logic       shift_start;

  assign shift_start = wr_lo & hit_phase & wdat[phy_misc_pkg::B_SHIFT_EN];

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      phase_field_reg <= '0;
    end else if (wr_lo && hit_phase) begin
      phase_field_reg <= fold_phase(wdat[3:0]);
    end
  end

  phase_stepper #(
    .PHASE_W       (phy_misc_pkg::PHASE_W),
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_stepper (
    .clk    (clk),
    .rst_n  (core_rst_n),
    .start  (shift_start),
    .target (fold_phase(wdat[3:0])),
    .busy   (phase_busy),
    .phase  (tx_clk_phase)
  );

  // ==========================================================
  // Power back-off and regulator
  logic [14:0] vr_reg;
  logic [15:0] bo_merged;
  logic [15:0] vr_merged;
  assign bo_merged = merge({7'h00, back_off_level, 6'h00}, wdat, wmask);
  assign vr_merged = merge({1'b0, vr_reg}, wdat, wmask);
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      back_off_level <= '0;
    end else if ((wr_lo || wr_hi) && hit_bo) begin
      back_off_level <= bo_merged[phy_misc_pkg::B_BACKOFF_LO +: 3];
    end
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      vr_reg               <= '0;
      regulator_power_down <= 1'b0;
    end else if ((wr_lo || wr_hi) && hit_vr) begin
      vr_reg <= vr_merged[14:0];
      if (wr_hi && wdat[phy_misc_pkg::B_REG_PD]) begin
        regulator_power_down <= 1'b1;
      end
    end
  end

  assign regulator_ctrl = vr_reg[3:0];

  // ==========================================================
  // Cable length detection
  logic       len_busy_reg;
  logic       len_done_reg;
  logic [7:0] len_result_reg;

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      length_detect_avg <= phy_misc_pkg::LEN_AVG_RESET;
    end else if (wr_lo && hit_len) begin
      length_detect_avg <= wdat[2:0];
    end
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      length_detect_start <= 1'b0;
      len_busy_reg        <= 1'b0;
      len_done_reg        <= 1'b0;
      len_result_reg      <= '0;
    end else begin
      length_detect_start <= 1'b0;
      if (len_busy_reg && length_detect_done) begin
        len_busy_reg   <= 1'b0;
        len_done_reg   <= 1'b1;
        len_result_reg <= length_detect_result;
      end else if (wr_hi && hit_len && wdat[phy_misc_pkg::B_LEN_START] && !len_busy_reg) begin
        length_detect_start <= 1'b1;
        len_busy_reg        <= 1'b1;
        len_done_reg        <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read mux and bus answer
  logic [15:0] rd_data;
  logic [31:0] rsp_dat_reg;
  always_comb begin
    rd_data = 16'h0000;
    if (in_range) begin
      case (idx)
        phy_misc_pkg::IDX_RESET_CTRL: rd_data[phy_misc_pkg::B_RESTART] = restart_active;
        phy_misc_pkg::IDX_PHASE: begin
          rd_data[3:0]                    = phase_field_reg;
          rd_data[phy_misc_pkg::B_SHIFT_EN] = phase_busy;
        end
        phy_misc_pkg::IDX_BACKOFF:   rd_data = phy_misc_pkg::BACKOFF_FIXED | {7'h00, back_off_level, 6'h00};
        phy_misc_pkg::IDX_REGULATOR: rd_data = {1'b0, vr_reg};
        phy_misc_pkg::IDX_LENGTH: begin
          rd_data[phy_misc_pkg::B_LEN_START] = len_busy_reg;
          rd_data[phy_misc_pkg::B_LEN_DONE]  = len_done_reg;
          rd_data[11:4]                      = len_result_reg;
          rd_data[2:0]                       = length_detect_avg;
        end
        default: rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ack_reg     <= 1'b0;
      rsp_dat_reg <= '0;
    end else begin
      ack_reg <= acc & ~ack_reg;
      if (acc && !ack_reg) begin
        rsp_dat_reg <= {16'h0000, rd_data};
      end
    end
  end

  assign wb_rsp = '{ack: ack_reg, dat: rsp_dat_reg};

  // ==========================================================
  // Assertions
  property p_ack_single;
    @(posedge clk) disable iff (!core_rst_n)
    (acc && !ack_reg) |=> ack_reg ##1 !ack_reg;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack not one cycle after request");
  property p_soft_reset;
    @(posedge clk) disable iff (!hw_rst_n)
    soft_req |=> !core_rst_n ##1 (restart_active == 1'b0 && regulator_power_down == 1'b0);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset did not reset");
  property p_restart_hold;
    @(posedge clk) disable iff (!core_rst_n)
    $fell(restart_active) |-> ($past(restart_cnt_reg) == '0 && phase_field_reg == $past(phase_field_reg));
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart ended early");
  property p_reserved_zero;
    @(posedge clk) disable iff (!core_rst_n)
    (ack_reg && in_range && idx == phy_misc_pkg::IDX_RESET_CTRL) |-> (wb_rsp.dat[13:0] == '0 && wb_rsp.dat[31:16] == '0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
  property p_phase_fold;
    @(posedge clk) disable iff (!core_rst_n)
    (wr_lo && hit_phase && wdat[3:0] > 4'(phy_misc_pkg::PHASE_LIMIT))
      |=> phase_field_reg == $past(wdat[3:0]) - 4'(phy_misc_pkg::PHASE_LIMIT);
  endproperty
  a_phase_fold: assert property (p_phase_fold) else $error("phase not folded modulo limit");
  property p_shift_busy;
    @(posedge clk) disable iff (!core_rst_n)
    shift_start && !phase_busy |=> phase_busy;
  endproperty
  a_shift_busy: assert property (p_shift_busy) else $error("shift enable did not hold");
  property p_backoff_read;
    @(posedge clk) disable iff (!core_rst_n)
    (ack_reg && in_range && idx == phy_misc_pkg::IDX_BACKOFF)
      |-> wb_rsp.dat[15:0] == (phy_misc_pkg::BACKOFF_FIXED | {7'h00, back_off_level, 6'h00});
  endproperty
  a_backoff_read: assert property (p_backoff_read) else $error("back-off read wrong");
  property p_reg_pd;
    @(posedge clk) disable iff (!core_rst_n)
    (wr_hi && hit_vr && wdat[phy_misc_pkg::B_REG_PD]) |=> regulator_power_down ##1 regulator_power_down;
  endproperty
  a_reg_pd: assert property (p_reg_pd) else $error("regulator not powered down");
  property p_avg_reset;
    @(posedge clk) disable iff (!hw_rst_n)
    $rose(core_rst_n) |-> length_detect_avg == phy_misc_pkg::LEN_AVG_RESET;
  endproperty
  a_avg_reset: assert property (p_avg_reset) else $error("averaging factor reset wrong");
  property p_len_start;
    @(posedge clk) disable iff (!core_rst_n)
    length_detect_start |-> len_busy_reg ##1 !length_detect_start;
  endproperty
  a_len_start: assert property (p_len_start) else $error("length start not a pulse");
  c_soft_reset: cover property (@(posedge clk) disable iff (!hw_rst_n) soft_req);
  c_shift_done: cover property (@(posedge clk) disable iff (!core_rst_n) $fell(phase_busy));
  c_len_done: cover property (@(posedge clk) disable iff (!core_rst_n) $rose(len_done_reg));

endmodule : phy_misc_control_regs

// >>> tb/mac_side_model.sv
`timescale 1ns/1ps

module mac_side_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       slow,
  input  wire logic       length_detect_start,
  input  wire logic [3:0] tx_clk_phase,
  output logic            length_detect_done,
  output logic [7:0]      length_detect_result,
  output int              jump_errs
);
  localparam logic [7:0] RESULT = 8'ha5;
  int         wait_cnt;
  logic       busy;
  logic [3:0] last_phase;

  // ==========================================
  // Length detection engine, prompt or slow
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy               <= 1'b0;
      wait_cnt           <= 0;
      length_detect_done <= 1'b0;
    end else begin
      length_detect_done <= 1'b0;
      if (length_detect_start) begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 40 : 0;
      end else if (busy) begin
        if (wait_cnt == 0) begin
          busy               <= 1'b0;
          length_detect_done <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 1;
        end
      end
    end
  end

  // Result is only held while done is shown
  assign length_detect_result = length_detect_done ? RESULT : ~RESULT;

  // ==========================================
  // Transmit clock may only move one step at a time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_phase <= 4'h0;
      jump_errs  <= 0;
    end else begin
      last_phase <= tx_clk_phase;
      if (tx_clk_phase != last_phase && 4'(tx_clk_phase - last_phase) != 4'h1 &&
          4'(last_phase - tx_clk_phase) != 4'h1) begin
        jump_errs <= jump_errs + 1;
      end
    end
  end
endmodule : mac_side_model

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
  logic                  clk;
  logic                  resetn;
  logic                  slow;
  phy_misc_pkg::wb_req_t wb_req;
  phy_misc_pkg::wb_rsp_t wb_rsp;
  logic                  restart_active;
  logic [3:0]            tx_clk_phase;
  logic [2:0]            back_off_level;
  logic                  regulator_power_down;
  logic [3:0]            regulator_ctrl;
  logic                  length_detect_start;
  logic [2:0]            length_detect_avg;
  logic                  length_detect_done;
  logic [7:0]            length_detect_result;
  int                    jump_errs;
  int                    n_fail;
  int                    tests_run;
  int                    prev;
  int                    f;
  int                    vals[5] = '{9, 12, 15, 10, 0};

  phy_misc_control_regs #(.SOFT_RESET_CYCLES(8), .RESTART_CYCLES(20), .SETTLE_CYCLES(5)) i_phy_misc_control_regs (
    .clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp), .restart_active(restart_active),
    .tx_clk_phase(tx_clk_phase), .back_off_level(back_off_level), .regulator_power_down(regulator_power_down),
    .regulator_ctrl(regulator_ctrl), .length_detect_start(length_detect_start),
    .length_detect_avg(length_detect_avg), .length_detect_done(length_detect_done),
    .length_detect_result(length_detect_result));

  mac_side_model i_mac_side_model (
    .clk(clk), .resetn(resetn), .slow(slow), .length_detect_start(length_detect_start),
    .tx_clk_phase(tx_clk_phase), .length_detect_done(length_detect_done),
    .length_detect_result(length_detect_result), .jump_errs(jump_errs));

  // ==========================================
  // Checking and closing
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // ==========================================
  // Wishbone classic single cycle
  task automatic wb_xfer(input logic we, input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h3, dat: {16'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) check("ack", 16'h0, 16'h1);
    r = wb_rsp.dat[15:0];
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input string name, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] r;
    wb_xfer(1'b0, a, 16'h0, r);
    check(name, r, exp);
  endtask : rd

  // Poll until a self-clearing bit drops
  task automatic wait_clear(input logic [15:0] a, input int b);
    int          n;
    logic [15:0] r;
    n = 0;
    do begin
      wb_xfer(1'b0, a, 16'h0, r);
      n++;
    end while (r[b] === 1'b1 && n < 100);
    if (n >= 100) check("self clear", r, 16'h0);
  endtask : wait_clear

  initial clk = 1'b0;
  always #20 clk = ~clk;

  initial begin
    #1_000_000;
    n_fail++;
    stop_test();
  end

  // ==========================================
  // Tests
  initial begin
    resetn    = 1'b0;
    slow      = 1'b0;
    wb_req    = '0;
    n_fail    = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd("reset ctrl", 16'h007c, 16'h0000);
    rd("phase", 16'h0108, 16'h0000);
    rd("backoff", 16'h02b8, 16'h8020);
    rd("length", 16'h0554, 16'h0001);
    check("avg out", 16'(length_detect_avg), 16'h1);
    wr(16'h007c, 16'h3fff);
    rd("reset rsvd", 16'h007c, 16'h0000);
    wr(16'h0108, 16'hffe0);
    rd("phase rsvd", 16'h0108, 16'h0000);
    prev = 0;
    foreach (vals[i]) begin
      f = vals[i] > 10 ? vals[i] - 10 : vals[i];
      wr(16'h0108, 16'h0010 | 16'(vals[i]));
      rd("shift busy", 16'h0108, 16'h0010 | 16'(f));
      wait_clear(16'h0108, 4);
      rd("phase field", 16'h0108, 16'(f));
      check("phase out", 16'(tx_clk_phase), 16'(f));
      prev = f;
    end
    wr(16'h0108, 16'h0003);
    repeat (20) @(posedge clk);
    check("no shift", 16'(tx_clk_phase), 16'(prev));
    rd("field only", 16'h0108, 16'h0003);
    for (int c = 0; c < 4; c++) begin
      wr(16'h02b8, 16'(c << 6));
      rd("backoff code", 16'h02b8, 16'h8020 | 16'(c << 6));
      check("backoff out", 16'(back_off_level), 16'(c));
    end
    rd("reg pre", 16'h0340, 16'h0000);
    wr(16'h0340, 16'h8005);
    rd("reg pd sc", 16'h0340, 16'h0005);
    check("reg pd", 16'(regulator_power_down), 16'h1);
    check("reg ctrl", 16'(regulator_ctrl), 16'h5);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      wr(16'h0554, 16'h8003);
      @(posedge clk);
      check("avg set", 16'(length_detect_avg), 16'h3);
      wait_clear(16'h0554, 15);
      rd("length res", 16'h0554, 16'h1a53);
    end
    wr(16'h007c, 16'h4000);
    rd("restart busy", 16'h007c, 16'h4000);
    check("restart out", 16'(restart_active), 16'h1);
    wait_clear(16'h007c, 14);
    check("restart end", 16'(restart_active), 16'h0);
    rd("kept phase", 16'h0108, 16'h0003);
    rd("kept backoff", 16'h02b8, 16'h80e0);
    wr(16'h0004, 16'hffff);
    rd("unmapped", 16'h0004, 16'h0000);
    wr(16'h007c, 16'h8000);
    repeat (12) @(posedge clk);
    check("sr pd", 16'(regulator_power_down), 16'h0);
    check("sr backoff", 16'(back_off_level), 16'h0);
    rd("sr self clear", 16'h007c, 16'h0000);
    rd("sr phase", 16'h0108, 16'h0000);
    rd("sr length", 16'h0554, 16'h0001);
    check("phase jumps", 16'(jump_errs), 16'h0);
    stop_test();
  end
endmodule : tb
